/* File: hw/tpm_pkg.sv */
package tpm_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_MHZ       = 10;
	localparam int unsigned CNT_W         = 16;
	localparam int unsigned HOLD_US       = 50;
	localparam int unsigned HOLD_CYC      = HOLD_US * CLK_MHZ;
	localparam int unsigned IDLE_US       = 1000;
	localparam int unsigned IDLE_CYC      = IDLE_US * CLK_MHZ;
	// Wake must be held for more than this time to leave shutdown
	localparam int unsigned SHUT_WAKE_US  = 10;
	localparam int unsigned SHUT_WAKE_CYC = SHUT_WAKE_US * CLK_MHZ + 1;
	localparam int unsigned LEAD_US       = 10;
	localparam int unsigned LEAD_CYC      = LEAD_US * CLK_MHZ;
	localparam int unsigned REPLY_US      = 1000;
	localparam int unsigned REPLY_CYC     = REPLY_US * CLK_MHZ;
	localparam int unsigned ADDR_CYC      = 8;
	localparam int unsigned DATA_CYC      = 16;
	localparam int unsigned GAP_CYC       = 8;
	localparam int unsigned RETRY_MAX     = 3;

	// ------------------------------------------------------------
	// Host register map
	// ------------------------------------------------------------
	localparam logic [7:0]  CTRL_OFS      = 8'h00;
	localparam logic [7:0]  STAT_OFS      = 8'h04;
	localparam logic [3:0]  CTRL_RST      = 4'h0;
	localparam int unsigned CTRL_FORCE    = 0;
	localparam int unsigned CTRL_LEAD     = 1;
	localparam int unsigned CTRL_I2C      = 2;
	localparam int unsigned CTRL_GO       = 3;

	// ------------------------------------------------------------
	// States
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		PWR_RUN,
		PWR_SLEEP,
		PWR_SHUT
	} tpm_pwr_t;

	typedef enum logic [2:0] {
		H_IDLE,
		H_LEAD,
		H_START,
		H_WAIT,
		H_DATA,
		H_GAP
	} tpm_hst_t;

endpackage : tpm_pkg

/* File: hw/tpm_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface tpm_link_if;
	logic wake_n;
	logic ser_frame;
	logic ser_addr;
	logic dev_ack;
	logic dev_nack;

	modport dev (
		input  wake_n,
		input  ser_frame,
		input  ser_addr,
		output dev_ack,
		output dev_nack
	);

	modport host (
		output wake_n,
		output ser_frame,
		output ser_addr,
		input  dev_ack,
		input  dev_nack
	);
endinterface : tpm_link_if
`default_nettype wire

/* File: hw/tpm_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module tpm_sync #(
	parameter int unsigned W   = 1,
	parameter logic [W-1:0] RST = '0
) (
	input  wire logic         clk_i,
	input  wire logic         srst_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta;

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			meta <= RST;
			q_o  <= RST;
		end else begin
			meta <= d_i;
			q_o  <= meta;
		end
	end
endmodule : tpm_sync
`default_nettype wire

/* File: hw/tpm_dev.sv */
// What this block does
// - Sleep enable: sleep between scans, gate serial clocks
// - Asleep until sampling period expires, then scan
// - Low wakeup pin forces run while held
// - After wake release, wait for traffic/scan, then sleep
// - I2C address match wakes; first address NACKed
// - Host resends address or uses wakeup pin
// - Host releases wakeup pin when finished
// - Pin wake holds run for 50 us
// - Addressed transfer in run: sleep 1 ms after STOP
// - I2C address wake: stay run 1 ms idle
// - UART start bit wakes, byte kept
// - Start bit at sleep entry loses frame
// - UART host: double SOF, lead wake, or retry
// - Shutdown stops scanning, serial and activity
// - Leave shutdown: wake >10 us, reset, touch
// - Resume run or sleep per saved sleep enable
// - Any electrode selectable as low power electrode
// - Low power enable arms wake, inhibits electrodes
// - No baseline tracking on low power electrode
// - Run is reset default, serial always on
// - Run scans at sampling period
`timescale 1ns/1ps
`default_nettype none
module tpm_dev #(
	parameter int unsigned IDLE_CYCLES = tpm_pkg::IDLE_CYC
) (
	input  wire logic              clk_i,
	input  wire logic              srst_i,
	input  wire logic              sleep_mode_enable_i,
	input  wire logic              shutdown_req_i,
	input  wire logic              i2c_select_i,
	input  wire logic [15:0]       sample_period_i,
	input  wire logic              scan_done_i,
	input  wire logic              low_power_electrode_wake_enable_i,
	input  wire logic [1:0]        lp_electrode_sel_i,
	input  wire logic              lp_touch_i,
	tpm_link_if.dev                link,
	output var tpm_pkg::tpm_pwr_t  mode_o,
	output logic                   serial_clk_en_o,
	output logic                   scan_start_o,
	output logic                   electrode_inhibit_o,
	output logic [3:0]             baseline_track_en_o,
	output logic [1:0]             lp_electrode_o,
	output logic                   frame_lost_o
);
	localparam logic [15:0] HOLD_LD = 16'(tpm_pkg::HOLD_CYC);
	localparam logic [15:0] IDLE_LD = 16'(IDLE_CYCLES);
	localparam logic [15:0] SHW_LD  = 16'(tpm_pkg::SHUT_WAKE_CYC);
	tpm_pkg::tpm_pwr_t state, next_state;
	logic [2:0]  sync_q;
	logic [15:0] per_cnt, hold_cnt, idle_cnt, shw_cnt;
	logic        wake_s, frame_s, addr_s, frame_q, shut_q, cfg_sleep;
	logic        scan_busy, tick, lost, ack, nack, keep;
	logic        frame_rise, frame_fall, shut_rise;
	logic        load_hold, load_idle, set_ack, set_nack, set_lost;
	function automatic logic [3:0] onehot(input logic [1:0] s);
		onehot = 4'h1 << s;
	endfunction : onehot
	tpm_sync #(
		.W   (3),
		.RST (3'h1)
	) u_sync (
		.clk_i  (clk_i),
		.srst_i (srst_i),
		.d_i    ({link.ser_addr, link.ser_frame, link.wake_n}),
		.q_o    (sync_q)
	);
	assign wake_s     = ~sync_q[0];
	assign frame_s    = sync_q[1];
	assign addr_s     = sync_q[2];
	assign frame_rise = frame_s & ~frame_q;
	assign frame_fall = ~frame_s & frame_q;
	assign shut_rise  = shutdown_req_i & ~shut_q;
	assign tick       = (state != tpm_pkg::PWR_SHUT) && (per_cnt == 16'h0000);
	assign mode_o     = state;
	// Anything still busy keeps the part awake
	assign keep = wake_s | (hold_cnt != 16'h0000) | (idle_cnt != 16'h0000)
		| scan_busy | tick | frame_q;

	// ------------------------------------------------------------
	// Power mode decision
	// ------------------------------------------------------------
	always_comb begin
		next_state = state;
		load_hold  = 1'b0;
		load_idle  = 1'b0;
		set_ack    = 1'b0;
		set_nack   = 1'b0;
		set_lost   = 1'b0;
		case (state)
			tpm_pkg::PWR_RUN: begin
				if (shut_rise) begin
					next_state = tpm_pkg::PWR_SHUT;
				end else begin
					if (!lost && !ack && !nack && frame_s) begin
						if (i2c_select_i && addr_s) begin
							set_ack = 1'b1;
						end else if (!i2c_select_i) begin
							set_ack = 1'b1;
						end
					end
					if (frame_fall && (ack || nack)) begin
						load_idle = 1'b1;
					end
					if (cfg_sleep && !keep) begin
						next_state = tpm_pkg::PWR_SLEEP;
						if (frame_rise) begin
							set_lost = 1'b1;
							set_ack  = 1'b0;
						end
					end
				end
			end
			tpm_pkg::PWR_SLEEP: begin
				if (shut_rise) begin
					next_state = tpm_pkg::PWR_SHUT;
				end else if (wake_s) begin
					next_state = tpm_pkg::PWR_RUN;
					load_hold  = 1'b1;
				end else if (tick) begin
					next_state = tpm_pkg::PWR_RUN;
				end else if (frame_s && !lost && !ack && !nack) begin
					if (!i2c_select_i) begin
						next_state = tpm_pkg::PWR_RUN;
						set_ack    = 1'b1;
					end else if (addr_s) begin
						next_state = tpm_pkg::PWR_RUN;
						set_nack   = 1'b1;
						load_idle  = 1'b1;
					end
				end
			end
			tpm_pkg::PWR_SHUT: begin
				if (shw_cnt >= SHW_LD ||
					(low_power_electrode_wake_enable_i && lp_touch_i)) begin
					next_state = cfg_sleep ? tpm_pkg::PWR_SLEEP
						: tpm_pkg::PWR_RUN;
				end
			end
			default: begin
				next_state = tpm_pkg::PWR_RUN;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			state <= tpm_pkg::PWR_RUN;
		end else begin
			state <= next_state;
		end
	end
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			frame_q <= 1'b0;
			shut_q  <= 1'b0;
		end else begin
			frame_q <= frame_s;
			shut_q  <= shutdown_req_i;
		end
	end

	// Sleep enable frozen while shut down, restored on exit
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			cfg_sleep <= 1'b0;
		end else if (state != tpm_pkg::PWR_SHUT && !shut_rise) begin
			cfg_sleep <= sleep_mode_enable_i;
		end
	end

	// ------------------------------------------------------------
	// Sampling period and scan
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (srst_i || state == tpm_pkg::PWR_SHUT) begin
			per_cnt <= sample_period_i;
		end else if (per_cnt == 16'h0000) begin
			per_cnt <= sample_period_i;
		end else begin
			per_cnt <= per_cnt - 16'h0001;
		end
	end
	always_ff @(posedge clk_i) begin
		if (srst_i || next_state == tpm_pkg::PWR_SHUT) begin
			scan_busy    <= 1'b0;
			scan_start_o <= 1'b0;
		end else begin
			scan_start_o <= tick;
			if (tick) begin
				scan_busy <= 1'b1;
			end else if (scan_done_i) begin
				scan_busy <= 1'b0;
			end
		end
	end
	always_ff @(posedge clk_i) begin
		if (srst_i || next_state == tpm_pkg::PWR_SHUT) begin
			hold_cnt <= 16'h0000;
		end else if (load_hold) begin
			hold_cnt <= HOLD_LD;
		end else if (hold_cnt != 16'h0000) begin
			hold_cnt <= hold_cnt - 16'h0001;
		end
	end
	always_ff @(posedge clk_i) begin
		if (srst_i || next_state == tpm_pkg::PWR_SHUT) begin
			idle_cnt <= 16'h0000;
		end else if (load_idle || frame_s) begin
			idle_cnt <= IDLE_LD;
		end else if (idle_cnt != 16'h0000) begin
			idle_cnt <= idle_cnt - 16'h0001;
		end
	end
	always_ff @(posedge clk_i) begin
		if (srst_i || state != tpm_pkg::PWR_SHUT || !wake_s) begin
			shw_cnt <= 16'h0000;
		end else if (shw_cnt != 16'hFFFF) begin
			shw_cnt <= shw_cnt + 16'h0001;
		end
	end

	// ------------------------------------------------------------
	// Serial answer, held until the frame ends
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (srst_i || !frame_s || next_state == tpm_pkg::PWR_SHUT) begin
			ack  <= 1'b0;
			nack <= 1'b0;
			lost <= 1'b0;
		end else begin
			if (set_ack) begin
				ack <= 1'b1;
			end
			if (set_nack) begin
				nack <= 1'b1;
			end
			if (set_lost) begin
				lost <= 1'b1;
			end
		end
	end
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			link.dev_ack    <= 1'b0;
			link.dev_nack   <= 1'b0;
			frame_lost_o    <= 1'b0;
			serial_clk_en_o <= 1'b1;
		end else begin
			link.dev_ack    <= ack;
			link.dev_nack   <= nack;
			frame_lost_o    <= set_lost;
			serial_clk_en_o <= (next_state == tpm_pkg::PWR_RUN);
		end
	end
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			electrode_inhibit_o <= 1'b0;
			baseline_track_en_o <= 4'hF;
			lp_electrode_o      <= 2'h0;
		end else begin
			lp_electrode_o      <= lp_electrode_sel_i;
			electrode_inhibit_o <= low_power_electrode_wake_enable_i;
			baseline_track_en_o <= low_power_electrode_wake_enable_i
				? ~onehot(lp_electrode_sel_i) : 4'hF;
		end
	end
endmodule : tpm_dev
`default_nettype wire

/* File: hw/tpm_host.sv */
`timescale 1ns/1ps
`default_nettype none
module tpm_host #(
	parameter int unsigned REPLY_CYCLES = tpm_pkg::REPLY_CYC
) (
	input  wire logic        clk_i,
	input  wire logic        srst_i,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	tpm_link_if.host         link
);
	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	localparam logic [15:0] LEAD_LD  = 16'(tpm_pkg::LEAD_CYC);
	localparam logic [15:0] ADDR_LD  = 16'(tpm_pkg::ADDR_CYC);
	localparam logic [15:0] DATA_LD  = 16'(tpm_pkg::DATA_CYC);
	localparam logic [15:0] GAP_LD   = 16'(tpm_pkg::GAP_CYC);
	localparam logic [15:0] REPLY_LD = 16'(REPLY_CYCLES);
	localparam logic [3:0]  RTRY_LIM = 4'(tpm_pkg::RETRY_MAX);

	tpm_pkg::tpm_hst_t st;
	logic [3:0]  ctrl;
	logic [1:0]  resp_s;
	logic [15:0] cnt;
	logic [3:0]  tries;
	logic        lead_wake;
	logic        ok;
	logic        fail;
	logic        go;
	logic        wr;

	assign wr = psel & penable & pwrite;
	assign go = wr && paddr == tpm_pkg::CTRL_OFS
		&& pwdata[tpm_pkg::CTRL_GO] && st == tpm_pkg::H_IDLE;

	tpm_sync #(
		.W   (2),
		.RST (2'h0)
	) u_sync (
		.clk_i  (clk_i),
		.srst_i (srst_i),
		.d_i    ({link.dev_nack, link.dev_ack}),
		.q_o    (resp_s)
	);

	// ------------------------------------------------------------
	// APB slave, zero wait states
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			ctrl    <= tpm_pkg::CTRL_RST;
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= 1'b1;
			if (wr && paddr == tpm_pkg::CTRL_OFS) begin
				ctrl <= {1'b0, pwdata[2:0]};
			end
			if (psel && !penable) begin
				pslverr <= paddr != tpm_pkg::CTRL_OFS
					&& paddr != tpm_pkg::STAT_OFS;
				case (paddr)
					tpm_pkg::CTRL_OFS: prdata <= {28'h0, ctrl};
					tpm_pkg::STAT_OFS: prdata <= {24'h0, link.wake_n,
						tries, fail, ok, st != tpm_pkg::H_IDLE};
					default: prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Transfer sequencer
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			st             <= tpm_pkg::H_IDLE;
			cnt            <= 16'h0000;
			tries          <= 4'h0;
			ok             <= 1'b0;
			fail           <= 1'b0;
			lead_wake      <= 1'b0;
			link.ser_frame <= 1'b0;
			link.ser_addr  <= 1'b0;
		end else begin
			if (cnt != 16'h0000) begin
				cnt <= cnt - 16'h0001;
			end
			case (st)
				tpm_pkg::H_IDLE: begin
					if (go) begin
						ok    <= 1'b0;
						fail  <= 1'b0;
						tries <= 4'h0;
						if (pwdata[tpm_pkg::CTRL_LEAD]) begin
							lead_wake <= 1'b1;
							cnt       <= LEAD_LD;
							st        <= tpm_pkg::H_LEAD;
						end else begin
							link.ser_frame <= 1'b1;
							cnt            <= ADDR_LD;
							st             <= tpm_pkg::H_START;
						end
					end
				end
				tpm_pkg::H_LEAD, tpm_pkg::H_GAP: begin
					if (cnt == 16'h0000) begin
						link.ser_frame <= 1'b1;
						cnt            <= ADDR_LD;
						st             <= tpm_pkg::H_START;
					end
				end
				tpm_pkg::H_START: begin
					if (cnt == 16'h0000) begin
						link.ser_addr <= ctrl[tpm_pkg::CTRL_I2C];
						cnt           <= REPLY_LD;
						st            <= tpm_pkg::H_WAIT;
					end
				end
				tpm_pkg::H_WAIT: begin
					if (resp_s[0]) begin
						cnt <= DATA_LD;
						st  <= tpm_pkg::H_DATA;
					end else if (resp_s[1] || cnt == 16'h0000) begin
						link.ser_frame <= 1'b0;
						link.ser_addr  <= 1'b0;
						if (tries < RTRY_LIM) begin
							tries <= tries + 4'h1;
							cnt   <= GAP_LD;
							st    <= tpm_pkg::H_GAP;
						end else begin
							fail      <= 1'b1;
							lead_wake <= 1'b0;
							st        <= tpm_pkg::H_IDLE;
						end
					end
				end
				tpm_pkg::H_DATA: begin
					if (cnt == 16'h0000) begin
						link.ser_frame <= 1'b0;
						link.ser_addr  <= 1'b0;
						lead_wake      <= 1'b0;
						ok             <= 1'b1;
						st             <= tpm_pkg::H_IDLE;
					end
				end
				default: begin
					st <= tpm_pkg::H_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			link.wake_n <= 1'b1;
		end else begin
			link.wake_n <= ~(ctrl[tpm_pkg::CTRL_FORCE] | lead_wake);
		end
	end
endmodule : tpm_host
`default_nettype wire

/* File: sim/tpm_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module tpm_checker #(
	parameter int unsigned IDLE_CYCLES = 200
) (
	input  wire logic        clk_i,
	input  wire logic        srst_i,
	input  wire logic        wake_n,
	input  wire logic        ser_frame,
	input  wire logic        ser_addr,
	input  wire logic        dev_ack,
	input  wire logic        dev_nack,
	input  wire logic        i2c_select_i,
	input  var  tpm_pkg::tpm_pwr_t mode_o,
	input  wire logic        serial_clk_en_o,
	input  wire logic        scan_start_o,
	input  wire logic        frame_lost_o,
	input  wire logic        electrode_inhibit_o,
	input  wire logic [3:0]  baseline_track_en_o,
	input  wire logic [1:0]  lp_electrode_o
);
	localparam tpm_pkg::tpm_pwr_t RUN = tpm_pkg::PWR_RUN;
	localparam tpm_pkg::tpm_pwr_t SLP = tpm_pkg::PWR_SLEEP;
	localparam tpm_pkg::tpm_pwr_t SHT = tpm_pkg::PWR_SHUT;
	localparam int HOLD = tpm_pkg::HOLD_CYC - 8;
	localparam int IDLE = IDLE_CYCLES - 2;
	logic [15:0] run_cnt;
	logic [15:0] gap_cnt;
	logic        pin_run;
	logic        answered;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (srst_i);

	// --------
	// Run length, bus idle time, answered frames
	// --------
	always_ff @(posedge clk_i) begin
		if (srst_i || mode_o != RUN) begin
			run_cnt <= 16'h0000;
			pin_run <= 1'b0;
		end else begin
			run_cnt <= run_cnt + {15'h0000, run_cnt != 16'hFFFF};
			// Run entered from sleep because the pin was low
			pin_run <= pin_run | ($past(mode_o) == SLP && !$past(wake_n, 3));
		end
	end
	always_ff @(posedge clk_i) begin
		if (srst_i || ser_frame)
			gap_cnt <= 16'h0000;
		else
			gap_cnt <= gap_cnt + {15'h0000, gap_cnt != 16'hFFFF};
	end
	always_ff @(posedge clk_i) begin
		if (srst_i || mode_o == SLP)
			answered <= 1'b0;
		else
			answered <= answered | dev_ack | dev_nack;
	end

	// --------
	// Assertions
	// --------
	reset_run_a: assert property (
		$past(srst_i) |-> mode_o == RUN && serial_clk_en_o)
		else $error("mode or serial clock wrong after reset");
	sleep_gate_a: assert property (
		mode_o == SLP && $past(mode_o) == SLP |-> !serial_clk_en_o)
		else $error("serial clock running in sleep");
	shut_quiet_a: assert property (
		mode_o == SHT && $past(mode_o) == SHT
		|-> !serial_clk_en_o && !scan_start_o && !dev_ack)
		else $error("activity during shutdown");
	pin_wake_a: assert property (
		mode_o == SLP && !wake_n ##1 (!wake_n) [*3] |-> ##[0:2] mode_o != SLP)
		else $error("wakeup pin did not leave sleep");
	wake_stay_a: assert property (
		(!wake_n) [*4] ##0 mode_o == RUN |=> mode_o == RUN)
		else $error("left run while wakeup pin held");
	pin_hold_a: assert property (
		pin_run && mode_o == RUN ##1 mode_o == SLP |-> $past(run_cnt) >= HOLD)
		else $error("pin wake run time too short");
	idle_run_a: assert property (
		answered && mode_o == RUN ##1 mode_o == SLP |-> $past(gap_cnt) >= IDLE)
		else $error("slept before bus idle time");
	ack_stand_a: assert property (
		dev_ack && ser_frame |=> dev_ack)
		else $error("answer dropped inside frame");
	ans_clear_a: assert property (
		(!ser_frame) [*6] |-> !dev_ack && !dev_nack)
		else $error("answer held after frame end");
	addr_first_a: assert property (
		$rose(dev_ack || dev_nack) && i2c_select_i |-> $past(ser_addr, 2))
		else $error("answer without own address");
	lp_base_a: assert property (
		baseline_track_en_o == (electrode_inhibit_o ?
			~(4'h1 << lp_electrode_o) : 4'hF))
		else $error("baseline tracking mask wrong");
	lost_drop_a: assert property (
		frame_lost_o |-> mode_o == SLP ##1 !dev_ack)
		else $error("lost frame answered");

	cover property (dev_nack);
	cover property (frame_lost_o);
	cover property (mode_o == SHT ##1 mode_o == SLP);
	cover property (pin_run && mode_o == RUN ##1 mode_o == SLP);
endmodule : tpm_checker
`default_nettype wire

/* File: sim/touch_controller_power_mode_manager_test.sv */
`timescale 1ns/1ps
`default_nettype none
module touch_controller_power_mode_manager_test;
	localparam int unsigned IDLE = 200;
	localparam tpm_pkg::tpm_pwr_t RUN = tpm_pkg::PWR_RUN;
	localparam tpm_pkg::tpm_pwr_t SLP = tpm_pkg::PWR_SLEEP;
	localparam tpm_pkg::tpm_pwr_t SHT = tpm_pkg::PWR_SHUT;
	localparam logic [7:0] CTRL = tpm_pkg::CTRL_OFS;
	logic              clk_i = 1'b0;
	logic              srst_i = 1'b1;
	logic              psel = 1'b0;
	logic              penable = 1'b0;
	logic              pwrite = 1'b0;
	logic [7:0]        paddr = 8'h00;
	logic [31:0]       pwdata = 32'h00000000;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	logic              sleep_en = 1'b0;
	logic              shut_req = 1'b0;
	logic              i2c_sel = 1'b0;
	logic [15:0]       period = 16'h00C8;
	logic              scan_done = 1'b0;
	logic              lp_en = 1'b0;
	logic [1:0]        lp_sel = 2'h0;
	logic              lp_touch = 1'b0;
	tpm_pkg::tpm_pwr_t mode;
	logic              sclk_en;
	logic              scan_start;
	logic              inhibit;
	logic [3:0]        base;
	logic [1:0]        lp_elec;
	logic              lost;
	logic [31:0]       rd;
	logic              err;
	logic [31:0]       c;
	int                failures = 0;
	int                comparisons = 0;
	int                seed = 47;
	int                cyc = 0;
	int                n;

	tpm_link_if u_tpm_link_if ();
	tpm_dev #(.IDLE_CYCLES(IDLE)) u_tpm_dev (
		.clk_i(clk_i), .srst_i(srst_i), .sleep_mode_enable_i(sleep_en),
		.shutdown_req_i(shut_req), .i2c_select_i(i2c_sel),
		.sample_period_i(period), .scan_done_i(scan_done),
		.low_power_electrode_wake_enable_i(lp_en),
		.lp_electrode_sel_i(lp_sel), .lp_touch_i(lp_touch),
		.link(u_tpm_link_if), .mode_o(mode), .serial_clk_en_o(sclk_en),
		.scan_start_o(scan_start), .electrode_inhibit_o(inhibit),
		.baseline_track_en_o(base), .lp_electrode_o(lp_elec),
		.frame_lost_o(lost));
	tpm_host #(.REPLY_CYCLES(IDLE)) u_tpm_host (
		.clk_i(clk_i), .srst_i(srst_i), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .link(u_tpm_link_if));
	tpm_checker #(.IDLE_CYCLES(IDLE)) u_tpm_checker (
		.clk_i(clk_i), .srst_i(srst_i), .wake_n(u_tpm_link_if.wake_n),
		.ser_frame(u_tpm_link_if.ser_frame),
		.ser_addr(u_tpm_link_if.ser_addr), .dev_ack(u_tpm_link_if.dev_ack),
		.dev_nack(u_tpm_link_if.dev_nack), .i2c_select_i(i2c_sel),
		.mode_o(mode), .serial_clk_en_o(sclk_en), .scan_start_o(scan_start),
		.electrode_inhibit_o(inhibit), .baseline_track_en_o(base),
		.lp_electrode_o(lp_elec), .frame_lost_o(lost));

	// --------
	// Bench tasks
	// --------
	always #50 clk_i = ~clk_i;
	// Scan engine finishes one cycle after each start
	always @(posedge clk_i) scan_done <= scan_start;
	always @(posedge clk_i) begin
		cyc = cyc + 1;
		if (cyc == 60000) begin
			failures = failures + 1;
			give_verdict();
		end
	end

	function automatic logic [31:0] exp_stat(input logic ok);
		return {24'h000000, 1'b1, 4'h0, ~ok, ok, 1'b0};
	endfunction : exp_stat
	function automatic logic [31:0] exp_base(input logic [1:0] s);
		return {28'h0000000, ~(4'h1 << s)};
	endfunction : exp_base

	task chk(input string what, input logic [31:0] seen, input logic [31:0] e);
		comparisons = comparisons + 1;
		if (seen !== e) begin
			failures = failures + 1;
			$display("unexpected %s expected %h seen %h", what, e, seen);
		end
	endtask : chk
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_i);
		penable <= 1'b1;
		@(posedge clk_i);
		while (pready !== 1'b1) @(posedge clk_i);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task wait_mode(input tpm_pkg::tpm_pwr_t m, input int lim);
		int k;
		k = 0;
		while (mode !== m && k < lim) begin
			@(posedge clk_i);
			k++;
		end
		chk("mode", 32'(mode), 32'(m));
	endtask : wait_mode
	task go(input logic [31:0] cv);
		int k;
		k = 0;
		apb(1'b1, CTRL, cv | 32'h00000008);
		do begin
			apb(1'b0, tpm_pkg::STAT_OFS, 32'h00000000);
			k++;
		end while (rd[0] !== 1'b0 && k < 500);
		// Wake pin settles one cycle after the sequencer goes idle
		apb(1'b0, tpm_pkg::STAT_OFS, 32'h00000000);
	endtask : go
	task give_verdict;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : give_verdict

	// --------
	// Scenarios
	// --------
	initial begin
		repeat (20) @(posedge clk_i);
		srst_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		chk("mode", 32'(mode), 32'(RUN));
		chk("serial clock", 32'(sclk_en), 32'h00000001);
		chk("baseline", 32'(base), 32'h0000000F);
		apb(1'b0, 8'h08, 32'h00000000);
		chk("slave error", 32'(err), 32'h00000001);
		$display("test reset done");
		sleep_en <= 1'b1;
		wait_mode(SLP, 50);
		chk("serial clock", 32'(sclk_en), 32'h00000000);
		for (n = 0; n < 400 && scan_start !== 1'b1; n++) @(posedge clk_i);
		chk("scan", 32'(scan_start), 32'h00000001);
		wait_mode(SLP, 20);
		apb(1'b1, CTRL, 32'h00000001);
		wait_mode(RUN, 12);
		repeat (600) @(posedge clk_i);
		chk("mode", 32'(mode), 32'(RUN));
		apb(1'b1, CTRL, 32'h00000000);
		wait_mode(SLP, 30);
		apb(1'b1, CTRL, 32'h00000001);
		repeat (10) @(posedge clk_i);
		apb(1'b1, CTRL, 32'h00000000);
		repeat (100) @(posedge clk_i);
		chk("mode", 32'(mode), 32'(RUN));
		wait_mode(SLP, 600);
		$display("test sleep and pin wake done");
		// Each serial mode, with and without a wake lead
		for (n = 0; n < 4; n++) begin
			i2c_sel <= n[1];
			wait_mode(SLP, IDLE + 700);
			// Start just after a scan so no period expiry wakes the part
			while (scan_start !== 1'b1) @(posedge clk_i);
			wait_mode(SLP, 20);
			go(32'(n << 1));
			chk("status", rd & 32'h87, exp_stat(1'b1));
			chk("retried", 32'(rd[6:3] != 4'h0), 32'(n == 2));
			wait_mode(SLP, IDLE + 700);
		end
		for (n = 0; n < 6; n++) begin
			c = $random(seed) & 32'h00000006;
			sleep_en <= 1'($random(seed));
			period <= 16'h0064 + 16'($random(seed) & 32'h000000FF);
			i2c_sel <= c[2];
			repeat ($random(seed) & 32'h0000003F) @(posedge clk_i);
			go(c);
			chk("status", rd & 32'h87, exp_stat(1'b1));
		end
		$display("test serial wake done");
		sleep_en <= 1'b0;
		wait_mode(RUN, IDLE + 700);
		shut_req <= 1'b1;
		wait_mode(SHT, 5);
		apb(1'b1, CTRL, 32'h00000001);
		repeat (60) @(posedge clk_i);
		chk("mode", 32'(mode), 32'(SHT));
		wait_mode(RUN, 80);
		apb(1'b1, CTRL, 32'h00000000);
		repeat (600) @(posedge clk_i);
		lp_sel <= 2'($random(seed));
		lp_en <= 1'b1;
		sleep_en <= 1'b1;
		shut_req <= 1'b0;
		repeat (3) @(posedge clk_i);
		chk("baseline", 32'(base), exp_base(lp_sel));
		chk("electrode", 32'(lp_elec), 32'(lp_sel));
		chk("inhibit", 32'(inhibit), 32'h00000001);
		shut_req <= 1'b1;
		wait_mode(SHT, 5);
		lp_touch <= 1'b1;
		wait_mode(SLP, 8);
		lp_touch <= 1'b0;
		lp_en <= 1'b0;
		shut_req <= 1'b0;
		@(posedge clk_i);
		shut_req <= 1'b1;
		wait_mode(SHT, 5);
		srst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		srst_i <= 1'b0;
		@(posedge clk_i);
		chk("mode", 32'(mode), 32'(RUN));
		$display("test shutdown done");
		give_verdict();
	end
endmodule : touch_controller_power_mode_manager_test
`default_nettype wire
